// [rail_voltage_code_regs.sv]
// Functional notes
// - Fifth converter sleep code is bits 7:1 of its sleep register, 25 mV steps.
// - Sixth converter normal code is bits 7:1, 10 mV or 25 mV range.
// - Bit 0 clear: slew down to lower code; set: let output decay passively.
// - Sixth converter sleep code is bits 7:1 of its sleep register, same ranges.
// - Second LDO sleep code is bits 7:4 of its register.
// - Second LDO normal code is bits 3:0 of its register.
// - Third LDO: sleep code bits 7:4, normal bits 3:0, same table.
`timescale 1ns/100ps
module rail_voltage_code_regs (
  input  wire logic                    clock_i,           // 20 MHz system clock
  input  wire logic                    rst_i,             // Synchronous reset, active high
  input  wire rail_code_pkg::reg_req_t req_i,             // Register request
  input  wire logic                    f_range_25mv_i,    // Sixth converter uses 25 mV steps
  input  wire logic                    conv_e_sleep_i,    // Fifth converter in sleep mode
  input  wire logic                    conv_f_sleep_i,    // Sixth converter in sleep mode
  input  wire logic                    ldo_b_sleep_i,     // Second LDO in sleep mode
  input  wire logic                    ldo_c_sleep_i,     // Third LDO in sleep mode
  output logic [7:0]                   rdata_o,           // Read data, one cycle after rd
  output logic [6:0]                   conv_e_sleep_voltage_code_o, // Fifth converter sleep code
  output logic [6:0]                   conv_f_code_o,     // Sixth converter applied code
  output rail_code_pkg::step_range_t   conv_f_range_o,    // Sixth converter step range
  output logic                         conv_f_slew_down_o, // Actively slewing to lower code
  output logic                         conv_f_decay_o,    // Passively decaying to lower code
  output logic [3:0]                   ldo_b_code_o,      // Second LDO applied code
  output logic [3:0]                   ldo_c_code_o       // Third LDO applied code
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] conv_e_sleep_code_r,  conv_e_sleep_code_nxt;
  logic [7:0] conv_f_normal_code_r, conv_f_normal_code_nxt;
  logic [7:0] conv_f_sleep_code_r,  conv_f_sleep_code_nxt;
  logic [7:0] ldo_b_codes_r,        ldo_b_codes_nxt;
  logic [7:0] ldo_c_codes_r,        ldo_c_codes_nxt;
  logic [7:0] rdata_nxt;

  // Drop bit 0 of sleep registers so reserved bit always reads zero
  function automatic logic [7:0] sleep_field(input logic [7:0] d);
    sleep_field = {d[7:1], 1'b0};
  endfunction

  // Write decode and read mux
  always_comb begin
    conv_e_sleep_code_nxt  = conv_e_sleep_code_r;
    conv_f_normal_code_nxt = conv_f_normal_code_r;
    conv_f_sleep_code_nxt  = conv_f_sleep_code_r;
    ldo_b_codes_nxt        = ldo_b_codes_r;
    ldo_c_codes_nxt        = ldo_c_codes_r;
    rdata_nxt              = rdata_o;
    if (req_i.wr) begin
      if (req_i.addr == rail_code_pkg::CONV_E_SLEEP_CODE_OFS) begin
        conv_e_sleep_code_nxt = sleep_field(req_i.wdata);
      end else if (req_i.addr == rail_code_pkg::CONV_F_NORMAL_CODE_OFS) begin
        conv_f_normal_code_nxt = req_i.wdata;
      end else if (req_i.addr == rail_code_pkg::CONV_F_SLEEP_CODE_OFS) begin
        conv_f_sleep_code_nxt = sleep_field(req_i.wdata);
      end else if (req_i.addr == rail_code_pkg::LDO_B_CODES_OFS) begin
        ldo_b_codes_nxt = req_i.wdata;
      end else if (req_i.addr == rail_code_pkg::LDO_C_CODES_OFS) begin
        ldo_c_codes_nxt = req_i.wdata;
      end
    end
    // Read returns the stored image; a same-cycle write shows next read
    if (req_i.rd) begin
      if (req_i.addr == rail_code_pkg::CONV_E_SLEEP_CODE_OFS) begin
        rdata_nxt = conv_e_sleep_code_r;
      end else if (req_i.addr == rail_code_pkg::CONV_F_NORMAL_CODE_OFS) begin
        rdata_nxt = conv_f_normal_code_r;
      end else if (req_i.addr == rail_code_pkg::CONV_F_SLEEP_CODE_OFS) begin
        rdata_nxt = conv_f_sleep_code_r;
      end else if (req_i.addr == rail_code_pkg::LDO_B_CODES_OFS) begin
        rdata_nxt = ldo_b_codes_r;
      end else if (req_i.addr == rail_code_pkg::LDO_C_CODES_OFS) begin
        rdata_nxt = ldo_c_codes_r;
      end else begin
        rdata_nxt = rail_code_pkg::UNMAPPED_READ;
      end
    end
  end

  // Register update
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      conv_e_sleep_code_r  <= rail_code_pkg::REG_RESET;
      conv_f_normal_code_r <= rail_code_pkg::REG_RESET;
      conv_f_sleep_code_r  <= rail_code_pkg::REG_RESET;
      ldo_b_codes_r        <= rail_code_pkg::REG_RESET;
      ldo_c_codes_r        <= rail_code_pkg::REG_RESET;
      rdata_o              <= rail_code_pkg::REG_RESET;
    end else begin
      conv_e_sleep_code_r  <= conv_e_sleep_code_nxt;
      conv_f_normal_code_r <= conv_f_normal_code_nxt;
      conv_f_sleep_code_r  <= conv_f_sleep_code_nxt;
      ldo_b_codes_r        <= ldo_b_codes_nxt;
      ldo_c_codes_r        <= ldo_c_codes_nxt;
      rdata_o              <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Applied codes towards the regulators
  // ****************************************************************
  logic [6:0] conv_e_nxt, conv_f_nxt;
  logic [3:0] ldo_b_nxt, ldo_c_nxt;
  logic       slew_nxt, decay_nxt;
  rail_code_pkg::step_range_t range_nxt;

  // Pick sleep or normal code per rail, the fifth converter always taking its sleep code; a drop in the sixth converter
  // code starts a slew or a passive decay, held until the code changes
  // again, since the analog side decides when the output has settled
  always_comb begin
    conv_e_nxt = conv_e_sleep_code_r[rail_code_pkg::CONV_CODE_LSB +: rail_code_pkg::CONV_CODE_W];
    conv_f_nxt = conv_f_sleep_i
      ? conv_f_sleep_code_r[rail_code_pkg::CONV_CODE_LSB +: rail_code_pkg::CONV_CODE_W]
      : conv_f_normal_code_r[rail_code_pkg::CONV_CODE_LSB +: rail_code_pkg::CONV_CODE_W];
    ldo_b_nxt = ldo_b_sleep_i
      ? ldo_b_codes_r[rail_code_pkg::LDO_SLEEP_LSB +: rail_code_pkg::LDO_CODE_W]
      : ldo_b_codes_r[rail_code_pkg::LDO_NORMAL_LSB +: rail_code_pkg::LDO_CODE_W];
    ldo_c_nxt = ldo_c_sleep_i
      ? ldo_c_codes_r[rail_code_pkg::LDO_SLEEP_LSB +: rail_code_pkg::LDO_CODE_W]
      : ldo_c_codes_r[rail_code_pkg::LDO_NORMAL_LSB +: rail_code_pkg::LDO_CODE_W];
    range_nxt = f_range_25mv_i ? rail_code_pkg::STEP_25MV : rail_code_pkg::STEP_10MV;
    slew_nxt  = conv_f_slew_down_o;
    decay_nxt = conv_f_decay_o;
    if (conv_f_nxt < conv_f_code_o) begin
      slew_nxt  = !conv_f_normal_code_r[rail_code_pkg::DECAY_BIT];
      decay_nxt = conv_f_normal_code_r[rail_code_pkg::DECAY_BIT];
    end else if (conv_f_nxt > conv_f_code_o) begin
      slew_nxt  = 1'b0;
      decay_nxt = 1'b0;
    end
  end

  // The rail sleep inputs are assumed already synchronous to clock_i
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      conv_e_sleep_voltage_code_o <= 7'h00;
      conv_f_code_o               <= 7'h00;
      conv_f_range_o              <= rail_code_pkg::STEP_10MV;
      conv_f_slew_down_o          <= 1'b0;
      conv_f_decay_o              <= 1'b0;
      ldo_b_code_o                <= 4'h0;
      ldo_c_code_o                <= 4'h0;
    end else begin
      conv_e_sleep_voltage_code_o <= conv_e_nxt;
      conv_f_code_o               <= conv_f_nxt;
      conv_f_range_o              <= range_nxt;
      conv_f_slew_down_o          <= slew_nxt;
      conv_f_decay_o              <= decay_nxt;
      ldo_b_code_o                <= ldo_b_nxt;
      ldo_c_code_o                <= ldo_c_nxt;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_E_SLEEP_CODE: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.wr && req_i.addr == rail_code_pkg::CONV_E_SLEEP_CODE_OFS
    |=> ##1 conv_e_sleep_voltage_code_o == $past(req_i.wdata[7:1], 2))
    else $error("fifth converter sleep code not applied");

  AST_F_NORMAL_CODE: assert property (@(posedge clock_i) disable iff (rst_i)
    !conv_f_sleep_i |=> conv_f_code_o == $past(conv_f_normal_code_r[7:1]))
    else $error("sixth converter normal code not applied");

  // A drop is seen one edge after it was launched, so the decay bit
  // that chose the response is the one of the previous cycle
  AST_F_DECAY: assert property (@(posedge clock_i) disable iff (rst_i)
    conv_f_code_o < $past(conv_f_code_o)
      |-> conv_f_decay_o == $past(conv_f_normal_code_r[0])
      && conv_f_slew_down_o == !$past(conv_f_normal_code_r[0]))
    else $error("slew or decay choice wrong on code drop");

  // A rising code ends any slew or decay in progress
  AST_F_RISE_CLEAR: assert property (@(posedge clock_i) disable iff (rst_i)
    conv_f_code_o > $past(conv_f_code_o) |-> !conv_f_slew_down_o && !conv_f_decay_o)
    else $error("slew or decay flag left set after code rise");

  // An unchanged code keeps the choice made at the last drop
  AST_F_FLAGS_HOLD: assert property (@(posedge clock_i) disable iff (rst_i)
    conv_f_code_o == $past(conv_f_code_o)
      |-> $stable(conv_f_slew_down_o) && $stable(conv_f_decay_o))
    else $error("slew or decay flag changed with steady code");

  AST_F_SLEEP_CODE: assert property (@(posedge clock_i) disable iff (rst_i)
    conv_f_sleep_i |=> conv_f_code_o == $past(conv_f_sleep_code_r[7:1]))
    else $error("sixth converter sleep code not applied");

  AST_LDO_B_SLEEP: assert property (@(posedge clock_i) disable iff (rst_i)
    ldo_b_sleep_i |=> ldo_b_code_o == $past(ldo_b_codes_r[7:4]))
    else $error("second LDO sleep code wrong");

  AST_LDO_B_NORMAL: assert property (@(posedge clock_i) disable iff (rst_i)
    !ldo_b_sleep_i |=> ldo_b_code_o == $past(ldo_b_codes_r[3:0]))
    else $error("second LDO normal code wrong");

  AST_LDO_C_CODE: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.wr && req_i.addr == rail_code_pkg::LDO_C_CODES_OFS ##1 ldo_c_sleep_i
    |=> ldo_c_code_o == $past(req_i.wdata[7:4], 2))
    else $error("third LDO sleep code wrong");

  AST_RESERVED_ZERO: assert property (@(posedge clock_i) disable iff (rst_i)
    req_i.rd && (req_i.addr == rail_code_pkg::CONV_E_SLEEP_CODE_OFS
      || req_i.addr == rail_code_pkg::CONV_F_SLEEP_CODE_OFS) |=> rdata_o[0] == 1'b0)
    else $error("reserved sleep bit reads nonzero");

  // Fifth converter code follows its register whatever the traffic
  AST_E_SLEEP_FOLLOW: assert property (@(posedge clock_i) disable iff (rst_i)
    1'b1 |=> conv_e_sleep_voltage_code_o == $past(conv_e_sleep_code_r[7:1]))
    else $error("fifth converter sleep code does not follow register");

  // Step range strap is passed on one cycle later
  AST_F_RANGE: assert property (@(posedge clock_i) disable iff (rst_i)
    1'b1 |=> conv_f_range_o == ($past(f_range_25mv_i)
      ? rail_code_pkg::STEP_25MV : rail_code_pkg::STEP_10MV))
    else $error("sixth converter step range wrong");

  // Third LDO sleep code applies in any sleeping cycle, not only after writes
  AST_LDO_C_SLEEP: assert property (@(posedge clock_i) disable iff (rst_i)
    ldo_c_sleep_i |=> ldo_c_code_o == $past(ldo_c_codes_r[7:4]))
    else $error("third LDO sleep code not applied");

  // Third LDO normal code applies while awake
  AST_LDO_C_NORMAL: assert property (@(posedge clock_i) disable iff (rst_i)
    !ldo_c_sleep_i |=> ldo_c_code_o == $past(ldo_c_codes_r[3:0]))
    else $error("third LDO normal code not applied");

endmodule

// [rail_code_pkg.sv]
package rail_code_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] CONV_E_SLEEP_CODE_OFS  = 8'h97;
  localparam logic [7:0] CONV_F_NORMAL_CODE_OFS = 8'h98;
  localparam logic [7:0] CONV_F_SLEEP_CODE_OFS  = 8'h99;
  localparam logic [7:0] LDO_B_CODES_OFS        = 8'h9a;
  localparam logic [7:0] LDO_C_CODES_OFS        = 8'h9b;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int         CONV_CODE_LSB   = 1;
  localparam int         CONV_CODE_W     = 7;
  localparam int         DECAY_BIT       = 0;
  localparam int         LDO_SLEEP_LSB   = 4;
  localparam int         LDO_NORMAL_LSB  = 0;
  localparam int         LDO_CODE_W      = 4;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [7:0] UNMAPPED_READ   = 8'h00;

  // Request from the serial host port register logic
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Step range of the sixth converter code
  typedef enum logic {
    STEP_10MV,
    STEP_25MV
  } step_range_t;

endpackage

// [rail_voltage_code_regs_tb.sv]
`timescale 1ns/100ps
module rail_voltage_code_regs_tb;
  // ****************************************************************
  // Stimulus, observed outputs and expectation queue
  // ****************************************************************
  logic                       clock_i;
  logic                       rst_i;
  logic                       f_range_25mv_i;
  logic [3:0]                 slp;
  rail_code_pkg::reg_req_t    req_i;
  logic [7:0]                 rdata_o;
  logic [6:0]                 conv_e_o;
  logic [6:0]                 conv_f_o;
  rail_code_pkg::step_range_t range_o;
  logic                       slew_o;
  logic                       decay_o;
  logic [3:0]                 ldo_b_o;
  logic [3:0]                 ldo_c_o;
  logic                       look;
  logic                       sel;
  logic [25:0]                exp_q[$];
  logic [7:0]                 sh[5];
  logic [6:0]                 prev_f;
  logic                       es;
  logic                       ed;
  int                         fail_count;
  int                         num_checks;
  // Offset table; the last entry sits outside the map
  logic [7:0] ofs[6] = '{rail_code_pkg::CONV_E_SLEEP_CODE_OFS, rail_code_pkg::CONV_F_NORMAL_CODE_OFS,
    rail_code_pkg::CONV_F_SLEEP_CODE_OFS, rail_code_pkg::LDO_B_CODES_OFS,
    rail_code_pkg::LDO_C_CODES_OFS, 8'h9c};

  rail_voltage_code_regs dut_u (.clock_i(clock_i), .rst_i(rst_i), .req_i(req_i),
    .f_range_25mv_i(f_range_25mv_i), .conv_e_sleep_i(slp[0]), .conv_f_sleep_i(slp[1]),
    .ldo_b_sleep_i(slp[2]), .ldo_c_sleep_i(slp[3]), .rdata_o(rdata_o),
    .conv_e_sleep_voltage_code_o(conv_e_o), .conv_f_code_o(conv_f_o), .conv_f_range_o(range_o),
    .conv_f_slew_down_o(slew_o), .conv_f_decay_o(decay_o), .ldo_b_code_o(ldo_b_o),
    .ldo_c_code_o(ldo_c_o));

  // ****************************************************************
  // Clock, checking and closing
  // ****************************************************************
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  task automatic check(input logic [25:0] seen, input logic [25:0] expv);
    num_checks++;
    if (seen !== expv) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Monitor samples mid-cycle so registered outputs have settled
  always @(negedge clock_i) begin
    if (look && exp_q.size() > 0) begin
      if (sel) check({1'b1, conv_e_o, conv_f_o, range_o, slew_o, decay_o, ldo_b_o, ldo_c_o},
                     exp_q.pop_front());
      else check({18'h0, rdata_o}, exp_q.pop_front());
    end
  end

  // ****************************************************************
  // Drivers
  // ****************************************************************
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    foreach (sh[i]) sh[i] = rail_code_pkg::REG_RESET;
    prev_f = 7'h00;
    es = 1'b0;
    ed = 1'b0;
  endtask

  task automatic wr(input int idx, input logic [7:0] d);
    @(posedge clock_i);
    req_i <= '{wr: 1'b1, rd: 1'b0, addr: ofs[idx], wdata: d};
    @(posedge clock_i);
    req_i.wr <= 1'b0;
    if (idx < 5) sh[idx] = (idx == 0 || idx == 2) ? {d[7:1], 1'b0} : d;
  endtask

  task automatic rd(input int idx);
    @(posedge clock_i);
    req_i <= '{wr: 1'b0, rd: 1'b1, addr: ofs[idx], wdata: 8'h00};
    exp_q.push_back({18'h0, (idx < 5) ? sh[idx] : rail_code_pkg::UNMAPPED_READ});
    @(posedge clock_i);
    req_i.rd <= 1'b0;
    look <= 1'b1;
    sel <= 1'b0;
    @(posedge clock_i);
    look <= 1'b0;
  endtask

  // Decay choice is taken from the normal register at the moment the code drops
  task automatic rail_chk();
    logic [6:0] fc;
    fc = slp[1] ? sh[2][7:1] : sh[1][7:1];
    if (fc < prev_f) begin
      es = ~sh[1][0];
      ed = sh[1][0];
    end else if (fc > prev_f) begin
      es = 1'b0;
      ed = 1'b0;
    end
    prev_f = fc;
    repeat (2) @(posedge clock_i);
    exp_q.push_back({1'b1, sh[0][7:1], fc, f_range_25mv_i, es, ed,
                     slp[2] ? sh[3][7:4] : sh[3][3:0], slp[3] ? sh[4][7:4] : sh[4][3:0]});
    look <= 1'b1;
    sel <= 1'b1;
    @(posedge clock_i);
    look <= 1'b0;
  endtask

  // ****************************************************************
  // Main sequence: reset values, random traffic, reset in mid-run
  // ****************************************************************
  initial begin
    rst_i = 1'b1;
    req_i = '0;
    slp = 4'h0;
    f_range_25mv_i = 1'b0;
    look = 1'b0;
    sel = 1'b0;
    fail_count = 0;
    num_checks = 0;
    void'($urandom(83));
    do_reset();
    for (int i = 0; i < 6; i++) rd(i);
    rail_chk();
    wr(2, 8'hff);
    rd(2);
    for (int n = 0; n < 2; n++) begin
      for (int i = 0; i < 60; i++) begin
        case ($urandom % 3)
          0: wr($urandom % 6, 8'($urandom));
          1: begin
            @(posedge clock_i);
            slp <= 4'($urandom);
            f_range_25mv_i <= 1'($urandom);
            @(posedge clock_i);
          end
          default: rd($urandom % 6);
        endcase
        rail_chk();
      end
      // Reset in mid-run must bring every register back to its reset value
      do_reset();
      for (int i = 0; i < 6; i++) rd(i);
    end
    results();
  end

  // Watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    repeat (5000) @(posedge clock_i);
    fail_count++;
    results();
  end
endmodule
